//--- src/pcc_pkg.sv
// Constants shared by the clock multiplier and supply select control block.
package pcc_pkg;

    // Register byte offsets on the APB slave.
    localparam logic [7:0]  PCC_OFF_CTRL        = 8'h00;
    localparam logic [7:0]  PCC_OFF_STATUS      = 8'h04;
    localparam logic [7:0]  PCC_OFF_MASK        = 8'h08;

    // Field positions in power_clock_control.
    localparam int unsigned PCC_BIT_FORCE_MAIN  = 10;
    localparam int unsigned PCC_BIT_MULT_SEL    = 11;
    localparam int unsigned PCC_BIT_MULT_EN     = 12;
    localparam int unsigned PCC_BIT_CLK_READY   = 13;
    localparam int unsigned PCC_CTRL_WIDTH      = 16;

    // Field positions in the event status and mask registers.
    localparam int unsigned PCC_EV_READY_RISE   = 0;
    localparam int unsigned PCC_EV_BUS_POWER    = 1;
    localparam int unsigned PCC_EV_WIDTH        = 2;

    // Reset values.
    localparam logic                    PCC_RST_FORCE_MAIN = 1'b0;
    localparam logic                    PCC_RST_MULT_SEL   = 1'b0;
    localparam logic                    PCC_RST_MULT_EN    = 1'b0;
    localparam logic [PCC_EV_WIDTH-1:0] PCC_RST_EV         = 2'h0;
    localparam logic [31:0]             PCC_RST_RDATA      = 32'h0000_0000;

    // PLL output of 48 MHz is divided by this ratio to give a 12 MHz system clock.
    localparam int unsigned PCC_PLL_MHZ         = 48;
    localparam int unsigned PCC_SYS_MHZ         = 12;
    localparam logic [2:0]  PCC_PLL_DIV         = 3'(PCC_PLL_MHZ / PCC_SYS_MHZ);

    // Multiplier warm-up count in CLK_SYS cycles.
    localparam int unsigned PCC_CNT_WIDTH       = 16;
    localparam int unsigned PCC_STARTUP_DEF     = 1024;

endpackage : pcc_pkg

//--- src/pcc_startup.sv
// Startup counter that gates the clock-ready flag of the clock multiplier.
`timescale 1ns/10ps
module pcc_startup
    import pcc_pkg::*;
#(
    parameter logic [PCC_CNT_WIDTH-1:0] STARTUP_CYCLES = PCC_CNT_WIDTH'(PCC_STARTUP_DEF)
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic ce,
    input  wire logic run,
    input  wire logic clear,
    output logic      ready
);

    logic [PCC_CNT_WIDTH-1:0] count_r;
    logic                     ready_r;

    // The count restarts from zero after any clear while the multiplier stays enabled.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            count_r <= '0;
            ready_r <= 1'b0;
        end else if (ce) begin
            if (clear || !run) begin
                count_r <= '0;                                        // see (RULE9) see (RULE12) see (RULE13)
                ready_r <= 1'b0;
            end else if (!ready_r) begin
                if (count_r >= STARTUP_CYCLES - PCC_CNT_WIDTH'(1)) begin
                    ready_r <= 1'b1;                                  // see (RULE10) see (RULE11)
                end else begin
                    count_r <= count_r + PCC_CNT_WIDTH'(1);
                end
            end
        end
    end

    assign ready = ready_r;

endmodule : pcc_startup

//--- src/pcc_top.sv
// Clock multiplier control and core supply select with an APB register slave.
//
// Overview of operation
// (RULE1) Force-main-supply set: never switch core supply to alternate input.
// (RULE2) Force-main-supply clear: use alternate supply whenever USB bus power is seen.
// (RULE3) Force-main-supply clears to zero on every reset.
// (RULE4) Multiplier select set: system clock from PLL once clock-ready is high.
// (RULE5) PLL stays enabled while USB is enabled or multiplier select is set.
// (RULE6) With multiplier select clear, USB enable alone decides the PLL enable; here multiplier enable set also keeps the PLL on.
// (RULE7) PLL 48 MHz output is divided by four for a 12 MHz clock.
// (RULE8) Multiplier enable zero turns the multiplier off, one turns it on.
// (RULE9) Clearing multiplier enable also clears clock-ready and multiplier select.
// (RULE10) Setting multiplier enable starts the startup count; clock-ready stays low meanwhile.
// (RULE11) Clock-ready reads zero while counting and one once the count completes.
// (RULE12) Clock-ready clears when multiplier select clears while USB enable is low.
// (RULE13) Clock-ready clears on entry into stop mode; here only when CE is high while STOP_ENTRY is asserted.
// (RULE14) Startup length is a parameter; clock-ready is read-only to software.
`timescale 1ns/10ps
module pcc_top
    import pcc_pkg::*;
#(
    parameter logic [PCC_CNT_WIDTH-1:0] STARTUP_CYCLES = PCC_CNT_WIDTH'(PCC_STARTUP_DEF)  // see (RULE14)
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RESETN,
    input  wire logic        CE,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        USB_EN,
    input  wire logic        VBUS_DET,
    input  wire logic        STOP_ENTRY,
    output logic             PLL_ENABLE,
    output logic             SYSCLK_SEL_PLL,
    output logic      [2:0]  PLL_DIV_RATIO,
    output logic             SUPPLY_ALT_SEL,
    output logic             IRQ
);

    ////////////////////////////////////////////////////////////////////////////////////////////////

    logic                    force_main_r;
    logic                    mult_sel_r;
    logic                    mult_sel_nxt;
    logic                    mult_en_r;
    logic                    mult_en_nxt;
    logic                    clock_ready;
    logic                    ready_clear;
    logic                    ready_d_r;
    logic [PCC_EV_WIDTH-1:0] ev_status_r;
    logic [PCC_EV_WIDTH-1:0] ev_status_nxt;
    logic [PCC_EV_WIDTH-1:0] ev_mask_r;
    logic [PCC_EV_WIDTH-1:0] ev_set;
    logic                    vbus_meta_r;
    logic                    vbus_sync_r;
    logic                    vbus_prev_r;
    logic [31:0]             prdata_r;
    logic                    pready_r;
    logic                    pslverr_r;
    logic                    pll_enable_r;
    logic                    sysclk_sel_r;
    logic [2:0]              pll_div_r;
    logic                    supply_alt_r;
    logic                    irq_r;
    logic                    setup_phase;
    logic                    access_done;
    logic                    wr_ctrl;
    logic                    wr_mask;
    logic                    rd_status;

    // Returns true when the bus address selects one of the mapped words.
    function automatic logic addr_mapped(input logic [7:0] addr);
        addr_mapped = (addr == PCC_OFF_CTRL) || (addr == PCC_OFF_STATUS) || (addr == PCC_OFF_MASK);
    endfunction : addr_mapped

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // APB handshake: setup is answered one cycle later with PREADY high in the access phase.

    assign setup_phase = PSEL && !PENABLE;
    assign access_done = PSEL && PENABLE && pready_r;
    assign wr_ctrl     = access_done && PWRITE && (PADDR == PCC_OFF_CTRL);
    assign wr_mask     = access_done && PWRITE && (PADDR == PCC_OFF_MASK);
    assign rd_status   = access_done && !PWRITE && (PADDR == PCC_OFF_STATUS);

    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (CE) begin
            pready_r  <= setup_phase;
            pslverr_r <= setup_phase && !addr_mapped(PADDR);
        end
    end

    // Read data is captured at the setup edge so that it stands through the access phase.
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            prdata_r <= PCC_RST_RDATA;
        end else if (CE) begin
            if (setup_phase && !PWRITE) begin
                prdata_r <= '0;
                case (PADDR)
                    PCC_OFF_CTRL: begin
                        prdata_r[PCC_BIT_FORCE_MAIN] <= force_main_r;
                        prdata_r[PCC_BIT_MULT_SEL]   <= mult_sel_r;
                        prdata_r[PCC_BIT_MULT_EN]    <= mult_en_r;
                        prdata_r[PCC_BIT_CLK_READY]  <= clock_ready;                 // see (RULE11)
                    end
                    PCC_OFF_STATUS: begin
                        prdata_r[PCC_EV_WIDTH-1:0] <= ev_status_r;
                    end
                    PCC_OFF_MASK: begin
                        prdata_r[PCC_EV_WIDTH-1:0] <= ev_mask_r;
                    end
                    default: begin
                        prdata_r <= '0;
                    end
                endcase
            end else if (!PSEL) begin
                prdata_r <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Control bits of power_clock_control. The clock-ready bit has no storage here.

    always_comb begin
        mult_en_nxt  = mult_en_r;
        mult_sel_nxt = mult_sel_r;
        if (wr_ctrl) begin
            mult_en_nxt  = PWDATA[PCC_BIT_MULT_EN];                                  // see (RULE8)
            mult_sel_nxt = PWDATA[PCC_BIT_MULT_SEL];
        end
        if (!mult_en_nxt) begin
            mult_sel_nxt = 1'b0;                                                     // see (RULE9)
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            force_main_r <= PCC_RST_FORCE_MAIN;                                      // see (RULE3)
            mult_sel_r   <= PCC_RST_MULT_SEL;
            mult_en_r    <= PCC_RST_MULT_EN;
        end else if (CE) begin
            if (wr_ctrl) begin
                force_main_r <= PWDATA[PCC_BIT_FORCE_MAIN];
            end
            mult_en_r  <= mult_en_nxt;
            mult_sel_r <= mult_sel_nxt;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            ev_mask_r <= PCC_RST_EV;
        end else if (CE && wr_mask) begin
            ev_mask_r <= PWDATA[PCC_EV_WIDTH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Multiplier startup counter and the conditions that drop clock-ready.

    // A select that falls with USB disabled, or stop mode entry while CE is high, restarts the warm-up.
    assign ready_clear = (mult_sel_r && !mult_sel_nxt && !USB_EN) || STOP_ENTRY;  // see (RULE12) see (RULE13)

    pcc_startup #(
        .STARTUP_CYCLES (STARTUP_CYCLES)
    ) u_startup (
        .clk    (CLK_SYS),
        .resetn (RESETN),
        .ce     (CE),
        .run    (mult_en_r),                                                         // see (RULE10)
        .clear  (ready_clear),
        .ready  (clock_ready)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Bus power detect arrives from a pin and is synchronised before use.

    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            vbus_meta_r <= 1'b0;
            vbus_sync_r <= 1'b0;
            vbus_prev_r <= 1'b0;
        end else if (CE) begin
            vbus_meta_r <= VBUS_DET;
            vbus_sync_r <= vbus_meta_r;
            vbus_prev_r <= vbus_sync_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Sticky events: a status read clears them, but a new event in that cycle survives.

    always_comb begin
        ev_set                    = '0;
        ev_set[PCC_EV_READY_RISE] = clock_ready && !ready_d_r;
        ev_set[PCC_EV_BUS_POWER]  = vbus_sync_r ^ vbus_prev_r;
        ev_status_nxt             = rd_status ? ev_set : (ev_status_r | ev_set);
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            ready_d_r   <= 1'b0;
            ev_status_r <= PCC_RST_EV;
            irq_r       <= 1'b0;
        end else if (CE) begin
            ready_d_r   <= clock_ready;
            ev_status_r <= ev_status_nxt;
            irq_r       <= |(ev_status_nxt & ev_mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Clock and supply outputs toward the analog section.

    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            pll_enable_r <= 1'b0;
            sysclk_sel_r <= 1'b0;
            pll_div_r    <= PCC_PLL_DIV;
        end else if (CE) begin
            // The multiplier runs for software, for the USB block, or while it clocks the core.
            pll_enable_r <= mult_en_nxt || mult_sel_nxt || USB_EN;                   // see (RULE5) see (RULE6) see (RULE8)
            // Switchover waits for the warm-up so the core never sees an unsettled PLL.
            sysclk_sel_r <= mult_sel_nxt && clock_ready && !ready_clear;             // see (RULE4)
            pll_div_r    <= PCC_PLL_DIV;                                             // see (RULE7)
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            supply_alt_r <= 1'b0;
        end else if (CE) begin
            supply_alt_r <= !force_main_r && vbus_sync_r;                            // see (RULE1) see (RULE2)
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////

    assign PRDATA         = prdata_r;
    assign PREADY         = pready_r;
    assign PSLVERR        = pslverr_r;
    assign PLL_ENABLE     = pll_enable_r;
    assign SYSCLK_SEL_PLL = sysclk_sel_r;
    assign PLL_DIV_RATIO  = pll_div_r;
    assign SUPPLY_ALT_SEL = supply_alt_r;
    assign IRQ            = irq_r;

endmodule : pcc_top

//--- tb/pcc_props.sv
// Port-level assertions for the clock multiplier and supply select block.
`timescale 1ns/10ps
module pcc_props
    import pcc_pkg::*;
(
    input wire logic        CLK_SYS,
    input wire logic        RESETN,
    input wire logic        CE,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        USB_EN,
    input wire logic        VBUS_DET,
    input wire logic        STOP_ENTRY,
    input wire logic        PLL_ENABLE,
    input wire logic        SYSCLK_SEL_PLL,
    input wire logic [2:0]  PLL_DIV_RATIO,
    input wire logic        SUPPLY_ALT_SEL
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESETN);

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_setup;
        CE && PSEL && !PENABLE;
    endsequence
    sequence s_ctrl_wr;
        CE && PSEL && PENABLE && PREADY && PWRITE && PADDR == PCC_OFF_CTRL;
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    AST_DIV_FOUR: assert property (PLL_DIV_RATIO == 3'h4)
        else $error("divide ratio is not four");
    AST_USB_KEEPS_PLL: assert property (CE && USB_EN |=> PLL_ENABLE)
        else $error("pll off while usb enabled");
    AST_FORCE_MAIN: assert property (s_ctrl_wr ##0 PWDATA[PCC_BIT_FORCE_MAIN] |=> ##1 !SUPPLY_ALT_SEL)
        else $error("alternate supply used while forced to main");
    AST_ALT_NEEDS_BUS: assert property (SUPPLY_ALT_SEL |-> $past(VBUS_DET, 3))
        else $error("alternate supply without bus power");
    AST_OFF_DROPS_SEL: assert property (s_ctrl_wr ##0 !PWDATA[PCC_BIT_MULT_EN] |=> ##1 !SYSCLK_SEL_PLL)
        else $error("clock still on pll after multiplier off");
    AST_STOP_DROPS: assert property (CE && STOP_ENTRY |-> ##2 !SYSCLK_SEL_PLL)
        else $error("clock still on pll after stop entry");
    AST_CLK_NEEDS_PLL: assert property (SYSCLK_SEL_PLL |-> PLL_ENABLE)
        else $error("clock on pll while pll disabled");
    AST_WARMUP_FIRST: assert property ($rose(SYSCLK_SEL_PLL) |-> $past(PLL_ENABLE, 8))
        else $error("switch to pll before warm-up");
    AST_READY_PULSE: assert property (s_setup |=> PREADY ##1 !PREADY)
        else $error("bus answer not a single access cycle");
    AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
        else $error("error response without ready");
endmodule : pcc_props

//--- tb/test_clock_multiplier_supply_select.sv
// Self-checking bench for the clock multiplier and supply select block.
`timescale 1ns/10ps
module test_clock_multiplier_supply_select
    import pcc_pkg::*;
;
    logic        CLK_SYS    = 1'b0;
    logic        RESETN     = 1'b0;
    logic        PSEL       = 1'b0;
    logic        PENABLE    = 1'b0;
    logic        PWRITE     = 1'b0;
    logic [7:0]  PADDR      = 8'h00;
    logic [31:0] PWDATA     = 32'h0;
    logic        USB_EN     = 1'b0;
    logic        VBUS_DET   = 1'b0;
    logic        STOP_ENTRY = 1'b0;
    logic        CE         = 1'b1;
    logic [31:0] PRDATA;
    logic        PREADY, PSLVERR, PLL_ENABLE, SYSCLK_SEL_PLL, SUPPLY_ALT_SEL, IRQ;
    logic [2:0]  PLL_DIV_RATIO;
    int          fail_count = 0;
    int          n_compared = 0;

    pcc_top #(.STARTUP_CYCLES(16'h0008)) uut (.*);

    initial begin
        forever #12.5 CLK_SYS = ~CLK_SYS;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic pin(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : pin
    task automatic cyc(input int n);
        repeat (n) @(negedge CLK_SYS);
    endtask : cyc
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r,
                       output logic e);
        @(posedge CLK_SYS);
        PSEL   <= 1'b1;
        PWRITE <= w;
        PADDR  <= a;
        PWDATA <= wd;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK_SYS);
        end while (PREADY !== 1'b1);
        r = PRDATA;
        e = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
        pin(e, exp_err);
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_startup();
        wr(PCC_OFF_MASK, 32'h3);
        wr(PCC_OFF_CTRL, 32'h1800);
        cyc(2);
        pin(PLL_ENABLE, 1'b1);
        pin(SYSCLK_SEL_PLL, 1'b0);
        rd(PCC_OFF_CTRL, 32'h1800, 1'b0);
        cyc(6);
        pin(SYSCLK_SEL_PLL, 1'b1);
        pin(IRQ, 1'b1);
        rd(PCC_OFF_CTRL, 32'h3800, 1'b0);
        rd(PCC_OFF_STATUS, 32'h1, 1'b0);
        cyc(2);
        pin(IRQ, 1'b0);
        wr(PCC_OFF_CTRL, 32'h1000);
        rd(PCC_OFF_CTRL, 32'h1000, 1'b0);
        wr(PCC_OFF_CTRL, 32'h2800);
        rd(PCC_OFF_CTRL, 32'h0, 1'b0);
        cyc(2);
        pin(PLL_ENABLE, 1'b0);
    endtask : t_startup
    task automatic t_usb();
        wr(PCC_OFF_MASK, 32'h0);
        @(posedge CLK_SYS);
        USB_EN <= 1'b1;
        cyc(2);
        pin(PLL_ENABLE, 1'b1);
        wr(PCC_OFF_CTRL, 32'h1800);
        cyc(12);
        wr(PCC_OFF_CTRL, 32'h1000);
        rd(PCC_OFF_CTRL, 32'h3000, 1'b0);
        rd(PCC_OFF_STATUS, 32'h1, 1'b0);
        pin(IRQ, 1'b0);
        wr(PCC_OFF_CTRL, 32'h0);
        @(posedge CLK_SYS);
        USB_EN <= 1'b0;
        cyc(2);
        pin(PLL_ENABLE, 1'b0);
    endtask : t_usb
    task automatic t_supply();
        wr(PCC_OFF_MASK, 32'h2);
        @(posedge CLK_SYS);
        VBUS_DET <= 1'b1;
        cyc(4);
        pin(SUPPLY_ALT_SEL, 1'b1);
        pin(IRQ, 1'b1);
        rd(PCC_OFF_STATUS, 32'h2, 1'b0);
        wr(PCC_OFF_CTRL, 32'h400);
        cyc(2);
        pin(SUPPLY_ALT_SEL, 1'b0);
        rd(PCC_OFF_CTRL, 32'h400, 1'b0);
        @(posedge CLK_SYS);
        RESETN <= 1'b0;
        repeat (2) @(posedge CLK_SYS);
        RESETN <= 1'b1;
        rd(PCC_OFF_CTRL, 32'h0, 1'b0);
        cyc(4);
        pin(SUPPLY_ALT_SEL, 1'b1);
    endtask : t_supply
    task automatic t_stop();
        wr(PCC_OFF_CTRL, 32'h1800);
        cyc(12);
        pin(SYSCLK_SEL_PLL, 1'b1);
        @(posedge CLK_SYS);
        CE         <= 1'b0;
        STOP_ENTRY <= 1'b1;
        @(posedge CLK_SYS);
        STOP_ENTRY <= 1'b0;
        cyc(2);
        pin(SYSCLK_SEL_PLL, 1'b1);
        @(posedge CLK_SYS);
        CE         <= 1'b1;
        @(posedge CLK_SYS);
        STOP_ENTRY <= 1'b1;
        @(posedge CLK_SYS);
        STOP_ENTRY <= 1'b0;
        cyc(2);
        pin(SYSCLK_SEL_PLL, 1'b0);
        rd(PCC_OFF_CTRL, 32'h1800, 1'b0);
        rd(8'h0c, 32'h0, 1'b1);
    endtask : t_stop

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (fail_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (2) @(posedge CLK_SYS);
        RESETN <= 1'b1;
        rd(PCC_OFF_CTRL, 32'h0, 1'b0);
        chk({29'h0, PLL_DIV_RATIO}, 32'h4);
        t_startup();
        t_usb();
        t_supply();
        t_stop();
        stop_test();
    end

    initial begin
        repeat (5000) @(posedge CLK_SYS);
        fail_count++;
        stop_test();
    end
endmodule : test_clock_multiplier_supply_select

bind pcc_top pcc_props u_props (.*);
